/* File: addressable_output_driver.sv */
// eight addressable output latches with pin and register write paths
// assumes pins are asynchronous to CLK_SYS, registers on AXI4-Lite
// assumes the host keeps address and data steady while enable is low
// assumes a bus command and a pin write may meet; the bus wins on a shared latch
// Summary of operation
// - eight latches, one chosen by 3-bit address
// - one-of-eight decode touches only addressed latch
// - latch keeps written on/off state afterwards
// - pin write accepted only while chip enable low; bus commands ignore it
// - master clear turns all outputs off together
// - master clear ignores the address inputs
// - sink output pulls low while latch on
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "aod_regs.svh"
module addressable_output_driver
  import aod_pkg::*;
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   NRST,
  input  wire logic [2:0]             SEL_ADDR,
  input  wire logic                   DATA_BIT,
  input  wire logic                   CHIP_EN_N,
  input  wire logic                   MASTER_CLEAR_N,
  output logic [7:0]                  DRV_O,
  output logic [7:0]                  DRV_OE,
  output logic [7:0]                  OUT_STATE,
  input  wire logic [`AOD_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  output logic [1:0]                  S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  input  wire logic [`AOD_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY
);
  // register strobes between the bus slave and the latch core
  aod_reg_if rif ();

  // pin side, after the two flops
  logic [5:0] pin_s1_q, pin_s2_q;
  sel_t       sel_s;
  logic       data_s, ce_n_s, clr_n_s;

  // latch image and the two write paths
  latch_vec_t latch_q, latch_d, pin_mask, sw_mask;

  // register side commands
  logic       sw_wr, sw_clear, sw_val;
  sel_t       sw_sel;

  // one-hot select, shared by both write paths and the checks
  function automatic latch_vec_t one_of_eight(input sel_t s);
    return latch_vec_t'(8'h01 << s);
  endfunction : one_of_eight

  // bus front end; reads answer one edge after the address is taken
  aod_axil_slave u_slave (
    .clk     (CLK_SYS),
    .nrst    (NRST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rif     (rif.slave)
  );

  // two-stage synchroniser; idle levels keep enable and clear inactive
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pin_s1_q <= `AOD_PIN_IDLE;
      pin_s2_q <= `AOD_PIN_IDLE;
    end else begin
      pin_s1_q <= {MASTER_CLEAR_N, CHIP_EN_N, DATA_BIT, SEL_ADDR};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign sel_s   = pin_s2_q[2:0];
  assign data_s  = pin_s2_q[3];
  assign ce_n_s  = pin_s2_q[4];
  assign clr_n_s = pin_s2_q[5];

  // register commands: CMD writes one latch, CLEAR empties all
  assign sw_wr    = rif.wr_stb && rif.wr_addr == `AOD_OFS_CMD;
  assign sw_clear = rif.wr_stb && rif.wr_addr == `AOD_OFS_CLEAR && rif.wr_data[`AOD_CLR_BIT];
  assign sw_sel   = rif.wr_data[`AOD_CMD_SEL_LSB +: 3];
  assign sw_val   = rif.wr_data[`AOD_CMD_VAL_BIT];

  // decode; no mask unless the path is enabled
  assign pin_mask = ce_n_s ? 8'h00 : one_of_eight(sel_s);
  assign sw_mask  = sw_wr ? one_of_eight(sw_sel) : 8'h00;

  // pin write first, bus write wins when both name the same latch
  always_comb begin
    latch_d = (latch_q & ~pin_mask) | (pin_mask & {8{data_s}});
    latch_d = (latch_d & ~sw_mask) | (sw_mask & {8{sw_val}});
  end

  // storage; clear overrides any write and needs no address
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      latch_q <= `AOD_LATCH_RST;
    end else if (!clr_n_s || sw_clear) begin
      latch_q <= `AOD_LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // sink variant: pull low while on, float while off
  // the pin value is fixed at 0; only the enable moves
  assign DRV_O     = 8'h00;
  assign DRV_OE    = latch_q;
  assign OUT_STATE = latch_q;

  // read mux; write-only commands read back as zero
  // the pin word shows synchronised levels, so software sees what the latches see
  always_comb begin
    unique case (rif.rd_addr)
      `AOD_OFS_LATCH: rif.rd_data = {24'h000000, latch_q};
      `AOD_OFS_PINS:  rif.rd_data = {26'h0, pin_s2_q};
      default:        rif.rd_data = 32'h0000_0000;
    endcase
  end

  // checks: each write and clear path is judged one edge after the synchronised inputs
  // master clear wins over any write, whatever the address lines show
  a_clear_all: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !clr_n_s |=> latch_q == 8'h00)
    else $error("master clear left an output on");

  // an addressed pin write in the same cycle must not survive the clear
  a_clear_noaddr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (!clr_n_s && !ce_n_s && data_s) |=> latch_q == 8'h00)
    else $error("addressed write beat master clear");

  // bus clear empties every latch just as the pin does
  a_bus_clear: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    sw_clear |=> latch_q == 8'h00)
    else $error("bus clear left an output on");

  // pin write: the addressed latch takes the data bit
  a_pin_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (clr_n_s && !sw_clear && !ce_n_s && !sw_wr) |=> latch_q[$past(sel_s)] == $past(data_s))
    else $error("addressed latch did not follow data");

  // pin write: every other latch keeps its state
  a_only_addressed: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (clr_n_s && !sw_clear && !sw_wr && !ce_n_s)
      |=> ((latch_q ^ $past(latch_q)) & ~one_of_eight($past(sel_s))) == 8'h00)
    else $error("write reached an unaddressed latch");

  // bus write: the addressed latch takes the value bit
  a_bus_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (sw_wr && clr_n_s && !sw_clear) |=> latch_q[$past(sw_sel)] == $past(sw_val))
    else $error("bus command did not reach latch");

  // bus write: upper data bits and the other latches stay out of it
  a_bus_only_addressed: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (sw_wr && clr_n_s && !sw_clear && ce_n_s)
      |=> ((latch_q ^ $past(latch_q)) & ~one_of_eight($past(sw_sel))) == 8'h00)
    else $error("bus write reached an unaddressed latch");

  // no enable and no command: nothing moves
  a_hold_disabled: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (ce_n_s && !sw_wr && clr_n_s && !sw_clear) |=> $stable(latch_q))
    else $error("latch changed with chip enable high");

  // three quiet cycles keep the image, so the host may walk away
  a_hold_state: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (ce_n_s && !sw_wr && clr_n_s && !sw_clear) [*3] |=> latch_q == $past(latch_q, 3))
    else $error("stored state drifted");

  // enable passes exactly two flops; both must have loaded out of reset
  a_sync_delay: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ($past(NRST) && $past(NRST, 2)) |-> ce_n_s == $past(CHIP_EN_N, 2))
    else $error("enable not two flops behind pin");

  // outputs stay released while reset holds
  a_reset_off: assert property (@(posedge CLK_SYS)
    !NRST |=> (DRV_OE == 8'h00 && OUT_STATE == 8'h00))
    else $error("output sinking during reset");

  // a cleared output stops sinking on the next edge
  a_sink_drive: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (!clr_n_s ##1 1'b1) |-> (DRV_OE == 8'h00 && DRV_O == 8'h00))
    else $error("cleared output still sinking");

  // main scenarios: pin write, both clears, single bus command, all on
  c_pin_write:   cover property (@(posedge CLK_SYS) disable iff (!NRST) !ce_n_s ##1 ce_n_s);
  c_master_clr:  cover property (@(posedge CLK_SYS) disable iff (!NRST)
    latch_q != 8'h00 ##1 !clr_n_s);
  c_bus_single:  cover property (@(posedge CLK_SYS) disable iff (!NRST) sw_wr && !sw_val);
  c_all_on:      cover property (@(posedge CLK_SYS) disable iff (!NRST) latch_q == 8'hff);
  c_bus_clear:   cover property (@(posedge CLK_SYS) disable iff (!NRST)
    latch_q != 8'h00 ##1 sw_clear);
endmodule : addressable_output_driver
`default_nettype wire

/* File: aod_regs.svh */
// register offsets, field positions and reset values of the output latch driver
// assumes a 4-bit byte address on a 32-bit AXI4-Lite bus
`ifndef AOD_REGS_SVH
`define AOD_REGS_SVH
`define AOD_ADDR_W      4
`define AOD_OFS_CMD     4'h0
`define AOD_OFS_CLEAR   4'h4
`define AOD_OFS_LATCH   4'h8
`define AOD_OFS_PINS    4'hc
`define AOD_CMD_SEL_LSB 0
`define AOD_CMD_VAL_BIT 3
`define AOD_CLR_BIT     0
`define AOD_LATCH_RST   8'h00
`define AOD_RESP_OKAY   2'b00
`define AOD_RESP_SLVERR 2'b10
`define AOD_SYNC_STAGES 2
`define AOD_PIN_IDLE    6'h30
`endif

/* File: aod_pkg.sv */
// types shared by the output latch driver and its register slave
// assumes nothing beyond a SystemVerilog compiler
package aod_pkg;
  typedef logic [7:0]  latch_vec_t;
  typedef logic [2:0]  sel_t;
  typedef logic [31:0] word_t;
  // write channel states of the bus slave
  typedef enum logic [1:0] {
    BW_COLLECT = 2'b01,
    BW_RESP    = 2'b10
  } bw_state_t;
endpackage : aod_pkg

/* File: aod_reg_if.sv */
// internal register access between the bus slave and the latch core
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface aod_reg_if;
  import aod_pkg::*;
  logic        wr_stb;
  logic [3:0]  wr_addr;
  word_t       wr_data;
  logic [3:0]  rd_addr;
  word_t       rd_data;
  modport slave (output wr_stb, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport core  (input wr_stb, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : aod_reg_if
`default_nettype wire

/* File: aod_axil_slave.sv */
// AXI4-Lite slave that turns bus cycles into register strobes
// assumes one clock, synchronous active-low reset, core answers reads combinationally
`timescale 1ns/1ps
`default_nettype none
`include "aod_regs.svh"
module aod_axil_slave
  import aod_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [`AOD_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`AOD_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  aod_reg_if.slave                    rif
);
  bw_state_t              state_q;
  logic                   aw_q, w_q, rvalid_q;
  logic [`AOD_ADDR_W-1:0] awaddr_q;
  word_t                  wdata_q;
  logic                   wlane_q;
  logic                   aw_hs, w_hs, aw_have, w_have;
  logic [`AOD_ADDR_W-1:0] wa;

  function automatic logic mapped(input logic [`AOD_ADDR_W-1:0] a);
    return a == `AOD_OFS_CMD || a == `AOD_OFS_CLEAR || a == `AOD_OFS_LATCH || a == `AOD_OFS_PINS;
  endfunction : mapped

  // address and data are taken in either order, held until both are here
  assign awready = (state_q == BW_COLLECT) && !aw_q;
  assign wready  = (state_q == BW_COLLECT) && !w_q;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign aw_have = aw_q || aw_hs;
  assign w_have  = w_q || w_hs;
  assign wa      = aw_q ? awaddr_q : awaddr;
  assign bvalid  = (state_q == BW_RESP);

  // write channel sequencing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q    <= BW_COLLECT;
      aw_q       <= 1'b0;
      w_q        <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= '0;
      wlane_q    <= 1'b0;
      bresp      <= `AOD_RESP_OKAY;
      rif.wr_stb <= 1'b0;
    end else begin
      rif.wr_stb <= 1'b0;
      unique case (state_q)
        BW_COLLECT: begin
          if (aw_hs) begin
            aw_q     <= 1'b1;
            awaddr_q <= awaddr;
          end
          if (w_hs) begin
            w_q     <= 1'b1;
            wdata_q <= wdata;
            wlane_q <= wstrb[0];
          end
          if (aw_have && w_have) begin
            state_q    <= BW_RESP;
            bresp      <= mapped(wa) ? `AOD_RESP_OKAY : `AOD_RESP_SLVERR;
            // only the low byte carries fields, so lane 0 must be enabled
            rif.wr_stb <= mapped(wa) && (w_q ? wlane_q : wstrb[0]);
          end
        end
        BW_RESP: begin
          if (bready) begin
            state_q <= BW_COLLECT;
            aw_q    <= 1'b0;
            w_q     <= 1'b0;
          end
        end
      endcase
    end
  end

  // strobe payload is valid in the same cycle as wr_stb
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rif.wr_addr <= '0;
      rif.wr_data <= '0;
    end else if (state_q == BW_COLLECT && aw_have && w_have) begin
      rif.wr_addr <= wa;
      rif.wr_data <= w_q ? wdata_q : wdata;
    end
  end

  // read channel: one cycle from address to data
  assign arready     = !rvalid_q;
  assign rvalid      = rvalid_q;
  assign rif.rd_addr = araddr;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata    <= '0;
      rresp    <= `AOD_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata    <= mapped(araddr) ? rif.rd_data : 32'h0000_0000;
      rresp    <= mapped(araddr) ? `AOD_RESP_OKAY : `AOD_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule : aod_axil_slave
`default_nettype wire

/* File: aod_host_model.sv */
// pin-side host model: drives latch address, data, chip enable and clear
// assumes the bench calls its tasks; the host drives every line push-pull
`timescale 1ns/1ps
`default_nettype none
module aod_host_model
  import aod_pkg::*;
(
  input  wire logic clk,
  output logic [2:0] sel,
  output logic       data,
  output logic       ce_n,
  output logic       clr_n
);
  logic busy;
  // clear idles high when unused
  initial begin
    sel = 3'h0;
    data = 1'b0;
    ce_n = 1'b1;
    clr_n = 1'b1;
    busy = 1'b0;
  end
  // unselected lines keep moving, so any stray write would show
  always @(posedge clk) begin
    if (!busy) begin
      sel <= 3'($urandom);
      data <= 1'($urandom);
    end
  end
  // one addressed write, lines held steady while enable is low
  task automatic pin_write(input sel_t a, input logic v);
    @(posedge clk);
    busy <= 1'b1;
    @(posedge clk);
    sel <= a;
    data <= v;
    ce_n <= 1'b0;
    repeat (4) @(posedge clk);
    ce_n <= 1'b1;
    @(posedge clk);
    busy <= 1'b0;
  endtask : pin_write
  // clear pulse, no address held: lines keep moving
  task automatic pulse_clear();
    @(posedge clk);
    clr_n <= 1'b0;
    repeat (4) @(posedge clk);
    clr_n <= 1'b1;
  endtask : pulse_clear
endmodule : aod_host_model
`default_nettype wire

/* File: addressable_output_driver_tb_top.sv */
// self-checking bench for the output latch driver: pin host model plus bus master
// assumes 25 MHz clock, sync active-low reset, offsets from aod_regs.svh
`timescale 1ns/1ps
`default_nettype none
`include "aod_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module addressable_output_driver_tb_top;
  import aod_pkg::*;
  logic clk = 1'b0, nrst = 1'b0;
  logic [2:0] sel;
  logic data, ce_n, clr_n;
  latch_vec_t drv_o, drv_oe, out_state, exp_lat, e8;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  word_t wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, v;
  logic [1:0] bresp, rresp, e2;
  logic [33:0] e34;
  logic [3:0] bcd;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  latch_vec_t sq[$];
  int fails = 0, checks_done = 0, i;
  event smp;
  initial forever #20 clk = ~clk;
  aod_host_model aod_host_model_inst (.clk(clk), .sel(sel), .data(data), .ce_n(ce_n),
    .clr_n(clr_n));
  addressable_output_driver addressable_output_driver_inst (.CLK_SYS(clk), .NRST(nrst),
    .SEL_ADDR(sel), .DATA_BIT(data), .CHIP_EN_N(ce_n), .MASTER_CLEAR_N(clr_n),
    .DRV_O(drv_o), .DRV_OE(drv_oe), .OUT_STATE(out_state), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // note the expected latch image; the monitor compares it once settled
  task automatic check_state();
    sq.push_back(exp_lat);
    @(negedge clk);
    -> smp;
  endtask : check_state
  // bus write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input word_t d, input logic [3:0] s,
      input logic [1:0] r);
    logic aw, w, b;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input word_t d, input logic [1:0] r);
    logic ar, rv;
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clk);
      ar = arvalid && arready;
      rv = rvalid;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
  endtask : axi_rd
  // monitor: latch image on request, bus answers as they are taken
  always @(smp) begin
    e8 = sq.pop_front();
    `CHK(out_state, e8)
    `CHK(drv_oe, e8)
    `CHK(drv_o, 8'h00)
  end
  always @(negedge clk) begin
    if (bvalid && bready) begin
      e2 = bq.pop_front();
      `CHK(bresp, e2)
    end
    if (rvalid && rready) begin
      e34 = rq.pop_front();
      `CHK({rresp, rdata}, e34)
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // watchdog sized well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(32'hc50211a2));
    exp_lat = 8'h00;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    check_state();
    axi_rd(`AOD_OFS_LATCH, 32'h0, `AOD_RESP_OKAY);
    $display("test reset done");
    // every address twice, random on/off, so some outputs get turned off
    for (i = 0; i < 16; i++) begin
      v = 1'($urandom);
      aod_host_model_inst.pin_write(i[2:0], v);
      exp_lat[i[2:0]] = v;
      check_state();
    end
    repeat (20) @(posedge clk);
    check_state();
    $display("test pin writes done");
    aod_host_model_inst.pin_write(3'h7, 1'b1);
    exp_lat[7] = 1'b1;
    check_state();
    aod_host_model_inst.pulse_clear();
    exp_lat = 8'h00;
    repeat (3) @(posedge clk);
    check_state();
    // clear over an addressed write: clear wins, the write lands once clear lifts
    fork
      aod_host_model_inst.pin_write(3'h3, 1'b1);
      aod_host_model_inst.pulse_clear();
    join
    exp_lat = 8'h08;
    repeat (2) @(posedge clk);
    check_state();
    $display("test pin clear done");
    // low nibble selects and switches, high nibble carries a segment digit
    for (i = 0; i < 8; i++) begin
      v = 1'($urandom);
      bcd = 4'($urandom % 10);
      axi_wr(`AOD_OFS_CMD, {24'h0, bcd, v, i[2:0]}, 4'hf, `AOD_RESP_OKAY);
      exp_lat[i[2:0]] = v;
    end
    repeat (2) @(posedge clk);
    check_state();
    axi_rd(`AOD_OFS_LATCH, {24'h0, exp_lat}, `AOD_RESP_OKAY);
    axi_wr(`AOD_OFS_CMD, {28'h0, ~exp_lat[5], 3'h5}, 4'h0, `AOD_RESP_OKAY);
    axi_rd(`AOD_OFS_CMD, 32'h0, `AOD_RESP_OKAY);
    axi_rd(4'h6, 32'h0, `AOD_RESP_SLVERR);
    axi_wr(4'h6, 32'h0000_000f, 4'hf, `AOD_RESP_SLVERR);
    check_state();
    $display("test bus writes done");
    axi_wr(`AOD_OFS_CMD, 32'h0000_000a, 4'hf, `AOD_RESP_OKAY);
    exp_lat[2] = 1'b1;
    axi_wr(`AOD_OFS_CLEAR, 32'h0, 4'hf, `AOD_RESP_OKAY);
    repeat (2) @(posedge clk);
    check_state();
    axi_wr(`AOD_OFS_CLEAR, 32'h1, 4'hf, `AOD_RESP_OKAY);
    exp_lat = 8'h00;
    repeat (2) @(posedge clk);
    check_state();
    $display("test bus clear done");
    final_report();
  end
endmodule : addressable_output_driver_tb_top
`default_nettype wire
